// *** core/dmr3_top.sv ***
// third mode register of the dram: command decode, field decode and
// the readout register path.
// assumes the command clock and command pins arrive asynchronously and
// that the command clock runs well below half of clk_i.
`include "dmr3_defines.svh"
module dmr3_top
  import dmr3_pkg::*;
#(
  parameter int TEMP_CYC = `DMR3_TEMP_CYC
) (
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  input  wire dmr3_pins_type pins_i,
  input  wire logic [2:0]    nom_term_i,
  input  wire logic [1:0]    temp_status_i,
  input  wire logic [31:0]   err_frame_i,
  output logic [21:0]        mode_reg_o,
  output dmr3_fmt_type       mpr_format_o,
  output logic [2:0]         wcl_o,
  output dmr3_fgr_type       refresh_mode_o,
  output logic               pda_en_o,
  output logic               gear_down_o,
  output logic               mpr_en_o,
  output logic [1:0]         mpr_page_o,
  output logic [7:0]         mpr_data_o,
  output logic               mpr_valid_o,
  output logic [2:0]         term_o,
  output logic [3:0]         burst_ui_o,
  output logic               rsvd_warn_o
);

  // ****************************************
  // pin sampling
  // ****************************************
  dmr3_pins_type pins_s;
  logic [$bits(dmr3_pins_type)-1:0] pins_raw;
  logic ck_d_ff;
  logic ck_rise;

  dmr3_sync #(
    .W ($bits(dmr3_pins_type))
  ) u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .d_i     (pins_i),
    .q_o     (pins_raw)
  );

  assign pins_s = dmr3_pins_type'(pins_raw);

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ck_d_ff <= 1'b0;
    end
    else
    begin
      ck_d_ff <= pins_s.ck;
    end
  end

  assign ck_rise = pins_s.ck & ~ck_d_ff;

  // ****************************************
  // command decode
  // ****************************************
  function automatic logic is_cmd(input dmr3_pins_type p,
                                  input logic ras, input logic cas, input logic we);
    is_cmd = ~p.cs_n & p.act_n & (p.ras_n == ras) & (p.cas_n == cas) & (p.we_n == we);
  endfunction

  logic [2:0] sel;
  logic       mode_set_command;
  logic       pda_ok;
  logic       ld_mr3;
  logic       ld_mr2;
  logic       rd_cmd;
  logic       wr_cmd;
  logic       sync_cmd;

  assign sel      = {pins_s.bg[0], pins_s.ba};
  assign mode_set_command      = ck_rise & is_cmd(pins_s, 1'b0, 1'b0, 1'b0);
  assign pda_ok   = ~pda_en_o | ~pins_s.pda_n;
  assign ld_mr3   = mode_set_command & pda_ok & (sel == `DMR3_SEL_MR3);
  assign ld_mr2   = mode_set_command & pda_ok & (sel == `DMR3_SEL_MR2);
  assign rd_cmd   = ck_rise & is_cmd(pins_s, 1'b1, 1'b0, 1'b1);
  assign wr_cmd   = ck_rise & is_cmd(pins_s, 1'b1, 1'b0, 1'b0);
  assign sync_cmd = ck_rise & ~pins_s.cs_n & pins_s.act_n & pins_s.ras_n
                    & pins_s.cas_n & pins_s.we_n;

  // ****************************************
  // mode registers
  // ****************************************
  logic [21:0] mode_reg_three_ff;
  logic [21:0] nxt_mode_reg_three;
  logic [2:0]  wterm_ff;
  logic        crc_en_ff;

  always_comb
  begin
    nxt_mode_reg_three = mode_reg_three_ff;
    if (ld_mr3)
    begin
      nxt_mode_reg_three = {pins_s.bg, pins_s.ba, pins_s.addr};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      mode_reg_three_ff <= `DMR3_RESET_VAL;
    end
    else
    begin
      mode_reg_three_ff <= nxt_mode_reg_three;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      wterm_ff  <= 3'h0;
      crc_en_ff <= 1'b0;
    end
    else if (ld_mr2)
    begin
      wterm_ff  <= pins_s.addr[`DMR2_WTERM_HI:`DMR2_WTERM_LO];
      crc_en_ff <= pins_s.addr[`DMR2_CRC_BIT];
    end
  end

  // reserved bits set by the controller are flagged, not acted on
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rsvd_warn_o <= 1'b0;
    end
    else if (ld_mr3)
    begin
      rsvd_warn_o <= pins_s.bg[1] | pins_s.addr[17] | pins_s.addr[13];
    end
  end

  // ****************************************
  // field decode
  // ****************************************
  function automatic logic [2:0] wcl_cycles(input logic [1:0] code);
    unique case (code)
      `DMR3_WCL_CODE4: wcl_cycles = `DMR3_WCL_4CK;
      `DMR3_WCL_CODE5: wcl_cycles = `DMR3_WCL_5CK;
      `DMR3_WCL_CODE6: wcl_cycles = `DMR3_WCL_6CK;
      default:         wcl_cycles = 3'h0;
    endcase
  endfunction

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      mode_reg_o     <= `DMR3_RESET_VAL;
      mpr_format_o   <= DMR3_FMT_SERIAL;
      wcl_o          <= `DMR3_WCL_4CK;
      refresh_mode_o <= DMR3_FGR_1X;
      pda_en_o       <= 1'b0;
      mpr_en_o       <= 1'b0;
      mpr_page_o     <= 2'h0;
    end
    else
    begin
      mode_reg_o     <= nxt_mode_reg_three;
      mpr_format_o   <= dmr3_fmt_type'(nxt_mode_reg_three[`DMR3_FMT_HI:`DMR3_FMT_LO]);
      wcl_o          <= wcl_cycles(nxt_mode_reg_three[`DMR3_WCL_HI:`DMR3_WCL_LO]);
      refresh_mode_o <= dmr3_fgr_type'(nxt_mode_reg_three[`DMR3_FGR_HI:`DMR3_FGR_LO]);
      pda_en_o       <= nxt_mode_reg_three[`DMR3_PDA_BIT];
      mpr_en_o       <= nxt_mode_reg_three[`DMR3_MPR_BIT];
      mpr_page_o     <= nxt_mode_reg_three[`DMR3_PAGE_HI:`DMR3_PAGE_LO];
    end
  end

  // ****************************************
  // gear-down entry
  // ****************************************
  typedef enum logic [1:0] {
    GD_HALF,
    GD_WAIT_SYNC,
    GD_QUARTER
  } gd_state_type;

  gd_state_type gd_state_ff;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      gd_state_ff <= GD_HALF;
    end
    else if (~nxt_mode_reg_three[`DMR3_GEAR_BIT])
    begin
      gd_state_ff <= GD_HALF;
    end
    else
    begin
      unique case (gd_state_ff)
        GD_HALF:      gd_state_ff <= GD_WAIT_SYNC;
        GD_WAIT_SYNC: gd_state_ff <= sync_cmd ? GD_QUARTER : GD_WAIT_SYNC;
        GD_QUARTER:   gd_state_ff <= GD_QUARTER;
        default:      gd_state_ff <= GD_HALF;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      gear_down_o <= 1'b0;
    end
    else
    begin
      gear_down_o <= (gd_state_ff == GD_QUARTER) & nxt_mode_reg_three[`DMR3_GEAR_BIT];
    end
  end

  // ****************************************
  // write frame and termination
  // ****************************************
  logic [3:0] wr_left_ff;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      burst_ui_o <= `DMR3_UI_NORMAL;
    end
    else
    begin
      burst_ui_o <= crc_en_ff ? `DMR3_UI_CRC : `DMR3_UI_NORMAL;
    end
  end

  // two UIs per command clock, so the window spans the whole frame in half as many command clocks
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      wr_left_ff <= 4'h0;
    end
    else if (wr_cmd & ~mpr_en_o)
    begin
      wr_left_ff <= {1'b0, burst_ui_o[3:1]};
    end
    else if (ck_rise && wr_left_ff != 4'h0)
    begin
      wr_left_ff <= wr_left_ff - 4'h1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      term_o <= 3'h0;
    end
    else if (pins_s.wlvl)
    begin
      term_o <= nom_term_i;
    end
    else if (wr_left_ff != 4'h0 && wterm_ff != 3'h0)
    begin
      term_o <= wterm_ff;
    end
    else
    begin
      term_o <= nom_term_i;
    end
  end

  // ****************************************
  // temperature status
  // ****************************************
  logic [31:0] temp_cnt_ff;
  logic [1:0]  temp_ff;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      temp_cnt_ff <= 32'h0000_0000;
      temp_ff     <= 2'h0;
    end
    else if (~mode_reg_three_ff[`DMR3_TEMP_BIT])
    begin
      temp_cnt_ff <= 32'h0000_0000;
      temp_ff     <= 2'h0;
    end
    else if (temp_cnt_ff == 32'h0000_0000)
    begin
      temp_cnt_ff <= 32'(TEMP_CYC - 1);
      temp_ff     <= temp_status_i;
    end
    else
    begin
      temp_cnt_ff <= temp_cnt_ff - 32'h0000_0001;
    end
  end

  // ****************************************
  // readout register
  // ****************************************
  logic [7:0] pat_q [4];
  logic       pat_wr;
  logic [1:0] loc;
  logic [7:0] page_byte;

  assign loc    = pins_s.ba;
  assign pat_wr = wr_cmd & mpr_en_o & (mpr_page_o == 2'h0);

  dmr3_pattern u_pat (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .wr_i    (pat_wr),
    .loc_i   (loc),
    .data_i  (pins_s.addr[7:0]),
    .q_o     (pat_q)
  );

  always_comb
  begin
    page_byte = 8'h00;
    unique case (mpr_page_o)
      2'h0: page_byte = pat_q[loc];
      2'h1: page_byte = err_frame_i[8*loc +: 8];
      2'h2:
      begin
        unique case (loc)
          2'h0: page_byte = {3'h0, temp_ff, 3'h0};
          2'h1: page_byte = mode_reg_three_ff[7:0];
          2'h2: page_byte = mode_reg_three_ff[15:8];
          2'h3: page_byte = {2'h0, mode_reg_three_ff[21:16]};
        endcase
      end
      2'h3: page_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      mpr_data_o  <= 8'h00;
      mpr_valid_o <= 1'b0;
    end
    else
    begin
      mpr_valid_o <= rd_cmd & mpr_en_o;
      if (rd_cmd & mpr_en_o)
      begin
        mpr_data_o <= page_byte;
      end
    end
  end

endmodule

// *** core/dmr3_defines.svh ***
// constants for the third mode register block: bit positions, codes,
// reset values and timing counts.
// assumes a 100 MHz core clock sampling the command clock pin.
//
// How it works
// - writes outside readout mode switch termination to a nonzero write termination
// - write leveling keeps nominal termination only
// - write CRC stretches frame to ten UIs
// - select code 011 loads this register
// - bits 12:11 pick readout format
// - bits 10:9 pick extra write latency
// - bits 8:6 pick refresh granularity
// - bit 5 keeps temperature status fresh
// - bit 4 enables per-device mode set masking
// - bit 3 picks internal clock ratio
// - quarter rate needs mode set plus sync
// - bit 2 turns on readout access
// - reads return selected readout location
// - bits 1:0 pick readout page
// - reset accepted in readout mode
// - pages hold patterns, error frame, readback
`ifndef DMR3_DEFINES_SVH
`define DMR3_DEFINES_SVH

`define DMR3_REG_W        22
`define DMR3_SEL_MR2      3'h2
`define DMR3_SEL_MR3      3'h3
`define DMR3_SEL_DNU      3'h7
`define DMR3_RESET_VAL    22'h00_0000
`define DMR3_FMT_HI       12
`define DMR3_FMT_LO       11
`define DMR3_WCL_HI       10
`define DMR3_WCL_LO       9
`define DMR3_FGR_HI       8
`define DMR3_FGR_LO       6
`define DMR3_TEMP_BIT     5
`define DMR3_PDA_BIT      4
`define DMR3_GEAR_BIT     3
`define DMR3_MPR_BIT      2
`define DMR3_PAGE_HI      1
`define DMR3_PAGE_LO      0
`define DMR2_WTERM_HI     11
`define DMR2_WTERM_LO     9
`define DMR2_CRC_BIT      12
`define DMR3_WCL_CODE4    2'h0
`define DMR3_WCL_CODE5    2'h1
`define DMR3_WCL_CODE6    2'h2
`define DMR3_WCL_4CK      3'h4
`define DMR3_WCL_5CK      3'h5
`define DMR3_WCL_6CK      3'h6
`define DMR3_UI_NORMAL    4'h8
`define DMR3_UI_CRC       4'hA
`define DMR3_PAT0_RST     8'h55
`define DMR3_PAT1_RST     8'h33
`define DMR3_PAT2_RST     8'h0F
`define DMR3_PAT3_RST     8'h00
`define DMR3_TEMP_MS      32
`define DMR3_CLK_KHZ      100000
`define DMR3_TEMP_CYC     (`DMR3_TEMP_MS * `DMR3_CLK_KHZ)

`endif

// *** core/dmr3_pkg.sv ***
// types shared by the third mode register block.
// assumes dmr3_defines.svh for widths.
`include "dmr3_defines.svh"
package dmr3_pkg;

  typedef enum logic [1:0] {
    DMR3_FMT_SERIAL,
    DMR3_FMT_PARALLEL,
    DMR3_FMT_STAGGERED,
    DMR3_FMT_RSVD
  } dmr3_fmt_type;

  typedef enum logic [2:0] {
    DMR3_FGR_1X,
    DMR3_FGR_2X,
    DMR3_FGR_4X,
    DMR3_FGR_R3,
    DMR3_FGR_R4,
    DMR3_FGR_OTF,
    DMR3_FGR_R6,
    DMR3_FGR_R7
  } dmr3_fgr_type;

  typedef struct packed {
    logic        ck;
    logic        cs_n;
    logic        act_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  bg;
    logic [1:0]  ba;
    logic [17:0] addr;
    logic        pda_n;
    logic        wlvl;
  } dmr3_pins_type;

endpackage

// *** core/dmr3_sync.sv ***
// two-flop synchroniser for a bundle of pin inputs.
// assumes inputs are asynchronous to clk_i.
module dmr3_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      meta_ff <= '0;
      q_o     <= '0;
    end
    else
    begin
      meta_ff <= d_i;
      q_o     <= meta_ff;
    end
  end
endmodule

// *** core/dmr3_pattern.sv ***
// writable calibration pattern store, page zero of the readout register.
// assumes writes and reads come from the command decoder on clk_i.
`include "dmr3_defines.svh"
module dmr3_pattern (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       wr_i,
  input  wire logic [1:0] loc_i,
  input  wire logic [7:0] data_i,
  output logic      [7:0] q_o [4]
);
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      q_o[0] <= `DMR3_PAT0_RST;
      q_o[1] <= `DMR3_PAT1_RST;
      q_o[2] <= `DMR3_PAT2_RST;
      q_o[3] <= `DMR3_PAT3_RST;
    end
    else if (wr_i)
    begin
      q_o[loc_i] <= data_i;
    end
  end
endmodule

// *** bench/dmr3_top_asserts.sv ***
// checker for the third mode register block, bound to its top module.
// assumes field outputs and mode_reg_o update on the same clock edge.
`include "dmr3_defines.svh"
module dmr3_top_asserts
  import dmr3_pkg::*;
#(
  parameter int TEMP_CYC = `DMR3_TEMP_CYC
) (
  input wire logic          clk_i,
  input wire logic          reset_i,
  input wire dmr3_pins_type pins_i,
  input wire logic [2:0]    nom_term_i,
  input wire logic [21:0]   mode_reg_o,
  input wire dmr3_fmt_type  mpr_format_o,
  input wire logic [2:0]    wcl_o,
  input wire dmr3_fgr_type  refresh_mode_o,
  input wire logic          pda_en_o,
  input wire logic          gear_down_o,
  input wire logic          mpr_en_o,
  input wire logic [1:0]    mpr_page_o,
  input wire logic          mpr_valid_o,
  input wire logic [2:0]    term_o,
  input wire logic [3:0]    burst_ui_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  // a mode set seen on the pins a few cycles back
  sequence s_set_seen;
    $past(pins_i.ck, 2) && !$past(pins_i.cs_n, 2) && !$past(pins_i.ras_n, 2);
  endsequence
  sequence s_sync_seen;
    $past(pins_i.ck, 2) && !$past(pins_i.cs_n, 2) && $past(pins_i.ras_n, 2);
  endsequence

  a_wcl_decode: assert property (wcl_o == ((mode_reg_o[10:9] == 2'h3) ? 3'h0 : 3'h4 + {1'b0, mode_reg_o[10:9]}))
    else $error("write latency does not match stored code");
  a_fmt_field: assert property (mpr_format_o == mode_reg_o[12:11])
    else $error("readout format does not match stored code");
  a_fgr_field: assert property (refresh_mode_o == mode_reg_o[8:6])
    else $error("refresh mode does not match stored code");
  a_ctrl_bits: assert property ({pda_en_o, mpr_en_o, mpr_page_o} == {mode_reg_o[4], mode_reg_o[2:0]})
    else $error("control bits do not match stored register");
  a_valid_pulse: assert property (mpr_valid_o |-> mpr_en_o ##1 !mpr_valid_o)
    else $error("readout valid not a single pulse in readout mode");
  a_burst_frame: assert property (burst_ui_o == 4'h8 || burst_ui_o == 4'hA)
    else $error("burst frame length illegal");
  a_hold_reg: assert property ($changed(mode_reg_o) |-> s_set_seen)
    else $error("register changed without a mode set");
  a_gear_entry: assert property ($rose(gear_down_o) |-> mode_reg_o[3] ##0 s_sync_seen)
    else $error("quarter rate entered without bit and sync");
  a_wlvl_nominal: assert property (pins_i.wlvl [*6] |-> term_o == $past(nom_term_i))
    else $error("termination not nominal in write leveling");
endmodule

bind dmr3_top dmr3_top_asserts #(.TEMP_CYC(TEMP_CYC)) dmr3_top_asserts_inst (.*);

// *** bench/dmr3_ctrl_model.sv ***
// controller model driving the command pins of the third mode register.
// assumes the bench clock; the command clock toggles only within a command.
module dmr3_ctrl_model
  import dmr3_pkg::*;
(
  input  wire logic     clk_i,
  output dmr3_pins_type pins_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // no activate is ever sent, so banks stay idle and precharged
  initial
  begin
    pins_o = '1;
    pins_o.ck = 1'b0;
    pins_o.wlvl = 1'b0;
  end

  // pins settle, ck rises 80 ns later, pins hold 120 ns past the rise
  task automatic issue(input logic [2:0] rcw, input logic [21:0] v, input logic pda_n);
    @(negedge clk_i);
    pins_o.cs_n = 1'b0;
    {pins_o.ras_n, pins_o.cas_n, pins_o.we_n} = rcw;
    {pins_o.bg, pins_o.ba, pins_o.addr} = v;
    pins_o.pda_n = pda_n;
    repeat (8) @(negedge clk_i);
    pins_o.ck = 1'b1;
    repeat (8) @(negedge clk_i);
    pins_o.ck = 1'b0;
    repeat (4) @(negedge clk_i);
    // released bg, ba and addr lines show the inverse of their last value; cs_n and pda_n return high
    pins_o.cs_n = 1'b1;
    pins_o.pda_n = 1'b1;
    {pins_o.bg, pins_o.ba, pins_o.addr} = ~v;
  endtask

  task automatic level(input logic on);
    @(negedge clk_i);
    pins_o.wlvl = on;
  endtask
endmodule

// *** bench/test_dmr3_top.sv ***
// self-checking bench for the third mode register block.
// assumes the controller model drives all command pins.
module test_dmr3_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dmr3_pkg::*;
  logic          clk_i = 1'b0;
  logic          reset_i = 1'b1;
  dmr3_pins_type pins_i;
  logic [2:0]    nom_term_i = 3'h5;
  logic [1:0]    temp_status_i = 2'h2;
  logic [31:0]   err_frame_i = 32'hA1B2_C3D4;
  logic [21:0]   mode_reg_o;
  dmr3_fmt_type  mpr_format_o;
  logic [2:0]    wcl_o;
  dmr3_fgr_type  refresh_mode_o;
  logic          pda_en_o;
  logic          gear_down_o;
  logic          mpr_en_o;
  logic [1:0]    mpr_page_o;
  logic [7:0]    mpr_data_o;
  logic          mpr_valid_o;
  logic [2:0]    term_o;
  logic [3:0]    burst_ui_o;
  logic          rsvd_warn_o;
  logic [7:0]    rd_byte;
  logic [21:0]   exp_reg;
  logic [7:0]    pat [4] = '{8'h55, 8'h33, 8'h0F, 8'h00};
  int            err_count = 0;
  int            check_count = 0;
  int            rd_seen = 0;

  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  dmr3_ctrl_model dmr3_ctrl_model_inst (.clk_i(clk_i), .pins_o(pins_i));
  dmr3_top #(.TEMP_CYC(20)) dmr3_top_inst (.clk_i(clk_i), .reset_i(reset_i), .pins_i(pins_i),
    .nom_term_i(nom_term_i), .temp_status_i(temp_status_i), .err_frame_i(err_frame_i),
    .mode_reg_o(mode_reg_o), .mpr_format_o(mpr_format_o), .wcl_o(wcl_o), .refresh_mode_o(refresh_mode_o),
    .pda_en_o(pda_en_o), .gear_down_o(gear_down_o), .mpr_en_o(mpr_en_o), .mpr_page_o(mpr_page_o),
    .mpr_data_o(mpr_data_o), .mpr_valid_o(mpr_valid_o), .term_o(term_o), .burst_ui_o(burst_ui_o),
    .rsvd_warn_o(rsvd_warn_o));

  always @(posedge clk_i)
  begin
    if (mpr_valid_o === 1'b1)
    begin
      rd_byte <= mpr_data_o;
      rd_seen <= rd_seen + 1;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic m3(input logic [17:0] a);
    dmr3_ctrl_model_inst.issue(3'b000, {4'h3, a}, 1'b1);
  endtask

  task automatic rd(input logic [1:0] loc, input logic [7:0] exp);
    int n;
    n = rd_seen;
    dmr3_ctrl_model_inst.issue(3'b101, {2'h0, loc, 18'h0_0000}, 1'b1);
    chk(rd_seen - n, 1);
    chk(rd_byte, exp);
  endtask

  task automatic summarize;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (100000) @(posedge clk_i);
    err_count++;
    summarize;
  end

  initial
  begin
    repeat (20) @(negedge clk_i);
    reset_i = 1'b0;
    repeat (3) @(negedge clk_i);
    chk({wcl_o, burst_ui_o, term_o}, {3'h4, 4'h8, 3'h5});
    for (int i = 0; i < 8; i++)
    begin
      exp_reg = {4'h3, 5'h00, i[1:0], i[1:0], i[2:0], 4'h0, i[1:0]};
      m3(exp_reg[17:0]);
      chk(mpr_format_o, i[1:0]);
      chk(wcl_o, (i[1:0] == 2'h3) ? 3'h0 : 3'h4 + {1'b0, i[1:0]});
      chk(refresh_mode_o, i[2:0]);
      chk(mpr_page_o, i[1:0]);
    end
    for (int j = 0; j < 8; j++)
    begin
      if (j != 3)
        dmr3_ctrl_model_inst.issue(3'b000, {1'b0, j[2:0], 18'h0_0000}, 1'b1);
      chk(mode_reg_o, exp_reg);
    end
    dmr3_ctrl_model_inst.issue(3'b000, 22'h2E_2000, 1'b1);
    chk(rsvd_warn_o, 1'b1);
    dmr3_ctrl_model_inst.issue(3'b000, 22'h08_1200, 1'b1);
    chk(burst_ui_o, 4'hA);
    dmr3_ctrl_model_inst.issue(3'b100, 22'h00_0000, 1'b1);
    chk(term_o, 3'h1);
    dmr3_ctrl_model_inst.level(1'b1);
    dmr3_ctrl_model_inst.issue(3'b100, 22'h00_0000, 1'b1);
    chk(term_o, 3'h5);
    dmr3_ctrl_model_inst.level(1'b0);
    m3(18'h0_0008);
    chk({gear_down_o, rsvd_warn_o}, 2'h0);
    dmr3_ctrl_model_inst.issue(3'b111, 22'h00_0000, 1'b1);
    chk(gear_down_o, 1'b1);
    m3(18'h0_0010);
    chk({gear_down_o, pda_en_o}, 2'h1);
    m3(18'h0_0013);
    chk(mpr_page_o, 2'h0);
    dmr3_ctrl_model_inst.issue(3'b000, 22'h0C_0004, 1'b0);
    chk({pda_en_o, mpr_en_o}, 2'h1);
    for (int k = 0; k < 4; k++)
      rd(k[1:0], pat[k]);
    dmr3_ctrl_model_inst.issue(3'b100, 22'h04_005A, 1'b1);
    rd(2'h1, 8'h5A);
    m3(18'h0_0005);
    for (int k = 0; k < 4; k++)
      rd(k[1:0], err_frame_i[8*k+:8]);
    m3(18'h0_0026);
    rd(2'h0, 8'h10);
    rd(2'h1, 8'h26);
    rd(2'h3, 8'h0C);
    temp_status_i = 2'h1;
    repeat (45) @(negedge clk_i);
    rd(2'h0, 8'h08);
    m3(18'h0_0007);
    rd(2'h0, 8'h00);
    reset_i = 1'b1;
    repeat (3) @(negedge clk_i);
    reset_i = 1'b0;
    repeat (3) @(negedge clk_i);
    chk({mpr_en_o, mode_reg_o}, 23'h0);
    m3(18'h0_0000);
    chk(mode_reg_o, 22'h0C_0000);
    summarize;
  end
endmodule
